// *** core/ssim_pkg.sv ***
// Purpose: Shared constants, types and helpers for the stop select block
// Assumes: 50 MHz ref_clk, 16-bit parameter words on a 32-bit bus
// Notes: Function codes are decimal settings held in hex form
package ssim_pkg;
  localparam int NTERM = 5;
  localparam int NFUNC = 21;
  localparam int CNT_W = 20;
  localparam int PRE_W = 26;
  // Byte addresses and word indices of the register words
  localparam logic [7:0] ADDR_STOP = 8'h00;
  localparam logic [7:0] ADDR_SEL0 = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h1c;
  localparam logic [5:0] WORD_STOP = 6'h00;
  localparam logic [5:0] WORD_CTRL = 6'h06;
  localparam logic [5:0] WORD_TOP = 6'h07;
  // Values after reset
  localparam logic [15:0] RST_STOP = 16'h270f;
  localparam logic [15:0] RST_SEL [NTERM] = '{16'h003c, 16'h003d,
    16'h0000, 16'h0001, 16'h0002};
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'hf3;
  localparam int CTRL_OVR_LSB = 4;
  // Stop method settings
  localparam logic [15:0] STOP_DECEL_FR = 16'h270f;
  localparam logic [15:0] STOP_DECEL_SD = 16'h22b8;
  localparam logic [15:0] STOP_COAST_MAX = 16'h0064;
  localparam logic [15:0] STOP_OFS_LO = 16'h03e8;
  localparam logic [15:0] STOP_OFS_HI = 16'h044c;
  localparam logic [15:0] CODE_NONE = 16'h270f;
  localparam logic [1:0] REGEN_HC = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Function indices into the decoded function vector
  localparam logic [4:0] FN_PERMIT = 5'h08;
  localparam logic [4:0] FN_SHUT = 5'h0d;
  localparam logic [4:0] FN_FWD = 5'h0f;
  localparam logic [4:0] FN_REV = 5'h10;
  localparam logic [4:0] FN_RESET = 5'h11;
  localparam logic [4:0] FN_NONE = 5'h1e;
  localparam logic [4:0] FN_BAD = 5'h1f;
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int FAST_MS = 2;
  localparam int SLOW_MS = 20;
  localparam int SEC_S = 1;
  localparam int FAST_CYC = CLK_HZ / 1000 * FAST_MS;
  localparam int SLOW_CYC = CLK_HZ / 1000 * SLOW_MS;
  localparam int SEC_CYC = CLK_HZ * SEC_S;

  typedef enum logic [3:0] {
    ST_STOP = 4'b0001,
    ST_RUN = 4'b0010,
    ST_DECEL = 4'b0100,
    ST_DELAY = 4'b1000
  } ssim_state_t;

  function automatic logic [4:0] code_index(input logic [15:0] c);
    case (c)
      16'h0000: code_index = 5'h00;
      16'h0001: code_index = 5'h01;
      16'h0002: code_index = 5'h02;
      16'h0003: code_index = 5'h03;
      16'h0004: code_index = 5'h04;
      16'h0005: code_index = 5'h05;
      16'h0007: code_index = 5'h06;
      16'h0008: code_index = 5'h07;
      16'h000a: code_index = FN_PERMIT;
      16'h000c: code_index = 5'h09;
      16'h000e: code_index = 5'h0a;
      16'h0010: code_index = 5'h0b;
      16'h0012: code_index = 5'h0c;
      16'h0018: code_index = FN_SHUT;
      16'h0019: code_index = 5'h0e;
      16'h003c: code_index = FN_FWD;
      16'h003d: code_index = FN_REV;
      16'h003e: code_index = FN_RESET;
      16'h0041: code_index = 5'h12;
      16'h0042: code_index = 5'h13;
      16'h0043: code_index = 5'h14;
      CODE_NONE: code_index = FN_NONE;
      default: code_index = FN_BAD;
    endcase
  endfunction : code_index

  // Forward code only on terminal 0, reverse only on terminal 1
  function automatic logic code_ok(input logic [15:0] c,
                                   input logic [2:0] t);
    logic [4:0] i;
    i = code_index(c);
    code_ok = (i != FN_BAD) && (i != FN_FWD || t == 3'h0) &&
              (i != FN_REV || t == 3'h1);
  endfunction : code_ok

  function automatic logic stop_ok(input logic [15:0] s);
    stop_ok = (s <= STOP_COAST_MAX) || (s == STOP_DECEL_FR) ||
              (s == STOP_DECEL_SD) ||
              (s >= STOP_OFS_LO && s <= STOP_OFS_HI);
  endfunction : stop_ok

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0] be);
    merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction : merge16
endpackage : ssim_pkg

// *** core/ssim_flt_if.sv ***
// Purpose: Filtered terminal levels from the input filter to the core
// Assumes: One bit per command terminal
// Notes: fast settles in the short window, slow in the long one
`timescale 1ns/1ps
interface ssim_flt_if;
  logic [4:0] fast;
  logic [4:0] slow;
  modport src (output fast, output slow);
  modport dst (input fast, input slow);
endinterface : ssim_flt_if

// *** core/ssim_filter.sv ***
// Purpose: Synchronise and debounce the five command terminals
// Assumes: term_in is asynchronous to ref_clk
// Notes: One shared stability counter per terminal serves both windows
`timescale 1ns/1ps
module ssim_filter import ssim_pkg::*; #(
  parameter int FAST_CYC_P = FAST_CYC,
  parameter int SLOW_CYC_P = SLOW_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [4:0] term_in,
  ssim_flt_if.src f
);
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] held;
  logic [4:0] fast_q;
  logic [4:0] slow_q;
  logic [CNT_W-1:0] cnt [NTERM];
  wire [CNT_W-1:0] fast_lim = CNT_W'(FAST_CYC_P);
  wire [CNT_W-1:0] slow_lim = CNT_W'(SLOW_CYC_P);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= term_in;
      sync2 <= sync1;
    end
  end

  // A level must stay put for the whole window before it is passed on
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 5'h00;
      fast_q <= 5'h00;
      slow_q <= 5'h00;
      for (int i = 0; i < NTERM; i++) cnt[i] <= '0;
    end else begin
      held <= sync2;
      for (int i = 0; i < NTERM; i++) begin
        if (sync2[i] != held[i]) cnt[i] <= '0;
        else if (cnt[i] < slow_lim) cnt[i] <= cnt[i] + 1'b1;
        if (cnt[i] >= fast_lim) fast_q[i] <= held[i];
        if (cnt[i] >= slow_lim) slow_q[i] <= held[i];
      end
    end
  end

  assign f.fast = fast_q;
  assign f.slow = slow_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_fast_window: assert property (
    (cnt[0] >= fast_lim) |=> (fast_q[0] == $past(held[0])))
    else $error("fast level did not follow a stable input");
endmodule : ssim_filter

// *** core/ssim_top.sv ***
// Purpose: Stop method selection and command terminal function mapping
// Assumes: ramp_done comes from the ramp generator on ref_clk
// Notes: Registers sit behind an AXI4-Lite slave, 16 bits per word
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module ssim_top import ssim_pkg::*; #(
  parameter int FAST_CYC_P = FAST_CYC,
  parameter int SLOW_CYC_P = SLOW_CYC,
  parameter int SEC_CYC_P = SEC_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [4:0] term_in,
  input wire logic ramp_done,
  output logic running,
  output logic decel_req,
  output logic reverse,
  output logic coasting,
  output logic start_pulse,
  output logic [NFUNC-1:0] func_out
);
  ssim_flt_if flt ();

  ssim_filter #(
    .FAST_CYC_P(FAST_CYC_P),
    .SLOW_CYC_P(SLOW_CYC_P)
  ) u_filter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .term_in(term_in),
    .f(flt.src)
  );

  logic [15:0] stop_method_param;
  logic [15:0] term_sel [NTERM];
  logic [7:0] ctrl;
  logic [7:0] aw_addr;
  logic [15:0] w_data;
  logic [1:0] w_strb;
  ssim_state_t state;
  ssim_state_t next_state;
  logic [PRE_W-1:0] presc;
  logic [6:0] sec_cnt;
  logic [NFUNC-1:0] func_now;
  logic permit_set;
  logic permit_fast;
  logic shut_fast;
  logic permit;
  logic [NFUNC-1:0] func_raw;
  logic [4:0] term_idx [NTERM];
  logic [15:0] view [8];

  // Register map view, also the source of the read-modify for byte lanes
  assign view[0] = stop_method_param;
  assign view[1] = term_sel[0];
  assign view[2] = term_sel[1];
  assign view[3] = term_sel[2];
  assign view[4] = term_sel[3];
  assign view[5] = term_sel[4];
  assign view[6] = {8'h00, ctrl};
  assign view[7] = {1'b0, sec_cnt, 3'h0, permit, reverse, coasting,
                    decel_req, running};

  // Write path: address and data are taken in either order
  wire wr_fire = !awready && !wready && !bvalid;
  wire [5:0] wr_word = aw_addr[7:2];
  wire [2:0] wr_term = 3'(wr_word[2:0] - 3'h1);
  wire wr_is_sel = (wr_word >= 6'h01) && (wr_word <= 6'h05);
  wire [15:0] wr_old = view[wr_word[2:0]];
  wire [15:0] wr_val = merge16(wr_old, w_data, w_strb);
  wire wr_ok = (wr_word == WORD_STOP && stop_ok(wr_val)) ||
               (wr_is_sel && code_ok(wr_val, wr_term)) ||
               (wr_word == WORD_CTRL);
  wire [5:0] rd_word = araddr[7:2];
  wire rd_hit = rd_word <= WORD_TOP;
  wire [15:0] rd_val = rd_hit ? view[rd_word[2:0]] : 16'h0000;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 16'h0000;
      w_strb <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_data <= wdata[15:0];
        w_strb <= wstrb[1:0];
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Rejected codes leave the selector unchanged and answer SLVERR
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_method_param <= RST_STOP;
      for (int i = 0; i < NTERM; i++) term_sel[i] <= RST_SEL[i];
      ctrl <= RST_CTRL;
    end else if (wr_fire && wr_ok) begin
      if (wr_word == WORD_STOP) stop_method_param <= wr_val;
      if (wr_is_sel) term_sel[wr_term] <= wr_val;
      if (wr_word == WORD_CTRL) ctrl <= wr_val[7:0] & CTRL_MASK;
    end
  end
  // Reset codes 60, 61, 0, 1, 2 come from RST_SEL

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {16'h0000, rd_val};
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Terminal to function mapping
  for (genvar g = 0; g < NTERM; g++) begin : g_idx
    assign term_idx[g] = code_index(term_sel[g]);
  end

  wire [1:0] regen = ctrl[1:0];
  wire ovr_any = |ctrl[CTRL_OVR_LSB+3:CTRL_OVR_LSB];
  wire mrs_as_permit = (regen == REGEN_HC) && !permit_set;
  // With regen at REGEN_HC and no permit terminal the shutoff input takes the permit role
  assign permit = permit_set ? permit_fast :
                  (mrs_as_permit ? shut_fast : 1'b1);
  wire shutoff = mrs_as_permit ? 1'b0 : shut_fast;

  always_comb begin
    func_raw = '0;
    permit_set = 1'b0;
    permit_fast = 1'b0;
    shut_fast = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      if (term_idx[i] < 5'(NFUNC))
        func_raw[term_idx[i]] = func_raw[term_idx[i]] | flt.slow[i];
      if (term_idx[i] == FN_PERMIT) begin
        permit_set = 1'b1;
        permit_fast = permit_fast | flt.fast[i];
      end
      if (term_idx[i] == FN_SHUT) shut_fast = shut_fast | flt.fast[i];
    end
  end

  // Separate block, so the permit remap does not feed back into its source
  always_comb begin
    func_now = func_raw;
    func_now[FN_PERMIT] = permit;
    func_now[FN_SHUT] = shutoff;
  end

  // Stop method decode
  wire mode_decel = (stop_method_param == STOP_DECEL_FR) ||
                    (stop_method_param == STOP_DECEL_SD);
  wire mode_ofs = (stop_method_param >= STOP_OFS_LO) &&
                  (stop_method_param <= STOP_OFS_HI);
  wire start_dir = mode_ofs ||
                   (stop_method_param == STOP_DECEL_SD);
  wire [15:0] delay_w = mode_ofs ? stop_method_param - STOP_OFS_LO :
                        stop_method_param;
  wire [6:0] delay_s = delay_w[6:0];
  wire fwd = func_now[FN_FWD];
  wire rev = func_now[FN_REV];
  // Both forward and reverse on means stop in the two-start mode
  wire run_req = start_dir ? fwd : (fwd ^ rev);
  wire dir_rev = start_dir ? rev : (rev && !fwd);
  wire cut_now = shutoff || !permit;
  wire sec_tick = presc == PRE_W'(SEC_CYC_P - 1);
  wire delay_done = sec_cnt >= delay_s;

  always_comb begin
    next_state = state;
    case (state)
      ST_STOP: begin
        if (run_req && !cut_now) next_state = ST_RUN;
      end
      ST_RUN: begin
        if (cut_now) next_state = ST_STOP;
        else if (!run_req && (mode_decel || ovr_any))
          next_state = ST_DECEL;
        else if (!run_req && delay_s == 7'h00) next_state = ST_STOP;
        else if (!run_req) next_state = ST_DELAY;
      end
      ST_DECEL: begin
        if (cut_now) next_state = ST_STOP;
        else if (run_req) next_state = ST_RUN;
        else if (ramp_done) next_state = ST_STOP;
      end
      ST_DELAY: begin
        if (cut_now) next_state = ST_STOP;
        else if (run_req) next_state = ST_RUN;
        else if (ovr_any) next_state = ST_DECEL;
        else if (delay_done) next_state = ST_STOP;
      end
      default: next_state = ST_STOP;
    endcase
  end

  wire next_coast = (next_state == ST_STOP) && (state != ST_STOP) &&
                    (state != ST_DECEL || cut_now);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_STOP;
      running <= 1'b0;
      decel_req <= 1'b0;
      reverse <= 1'b0;
      coasting <= 1'b0;
      start_pulse <= 1'b0;
      func_out <= '0;
    end else begin
      state <= next_state;
      running <= next_state != ST_STOP;
      // Delay phase keeps normal ramping, no decel request
      decel_req <= next_state == ST_DECEL;
      start_pulse <= (state == ST_STOP) && (next_state == ST_RUN);
      if (next_coast) coasting <= 1'b1;
      else if (next_state == ST_RUN) coasting <= 1'b0;
      if (next_state == ST_RUN) reverse <= dir_rev;
      func_out <= func_now;
    end
  end

  // Counter only runs in the delay phase, so a restart clears it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc <= '0;
      sec_cnt <= 7'h00;
    end else if (state != ST_DELAY || next_state != ST_DELAY) begin
      presc <= '0;
      sec_cnt <= 7'h00;
    end else if (sec_tick) begin
      presc <= '0;
      if (sec_cnt != 7'h7f) sec_cnt <= sec_cnt + 7'h01;
    end else begin
      presc <= presc + 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_decel_on_release: assert property (
    (state == ST_RUN && !run_req && !cut_now && mode_decel)
    |=> (state == ST_DECEL && decel_req && running))
    else $error("decel mode did not ramp down on release");
  chk_coast_expiry: assert property (
    (state == ST_DELAY && delay_done && !run_req && !cut_now && !ovr_any)
    |=> (!running && coasting))
    else $error("output not cut when the delay expired");
  chk_offset_delay: assert property (
    mode_ofs |-> (16'(delay_s) + STOP_OFS_LO == stop_method_param))
    else $error("offset delay not setting minus base");
  chk_start_dir_mode: assert property (
    (start_dir && state == ST_STOP && fwd && rev && !cut_now)
    |=> (running && reverse))
    else $error("start plus direction mode misread");
  chk_two_start_mode: assert property (
    (!start_dir && fwd && rev) |-> !run_req)
    else $error("both starts on must not run");
  chk_running_drop: assert property (
    (state != ST_STOP && cut_now) |=> (!running ##1 !running))
    else $error("running stayed high after cut");
  chk_delay_follow: assert property (
    (state == ST_DELAY) |-> (running && !decel_req))
    else $error("delay phase must keep normal ramp");
  chk_override_stop: assert property (
    (state == ST_RUN && ovr_any && !run_req && !cut_now && !mode_decel)
    |=> (state == ST_DECEL))
    else $error("override did not bypass coast delay");
  chk_coast_restart: assert property (
    (state == ST_STOP && coasting && run_req && !cut_now)
    |=> (start_pulse && !coasting))
    else $error("restart from coast missing start pulse");
  chk_shutoff_permit: assert property (
    mrs_as_permit |-> (permit == shut_fast && !shutoff))
    else $error("shutoff input not acting as permit");
  chk_sel_legal: assert property (
    code_ok(term_sel[0], 3'h0) && code_ok(term_sel[1], 3'h1) &&
    code_ok(term_sel[2], 3'h2) && code_ok(term_sel[3], 3'h3) &&
    code_ok(term_sel[4], 3'h4))
    else $error("illegal code in a selector");
  chk_timer_clear: assert property (
    (state == ST_DELAY && run_req && !cut_now) |=> (sec_cnt == 7'h00))
    else $error("delay counter not cleared on restart");

  cov_decel_stop: cover property (
    (state == ST_DECEL) ##1 (state == ST_STOP));
  cov_coast_cut: cover property (
    (state == ST_DELAY) ##1 (state == ST_STOP && coasting));
  cov_restart: cover property (
    (state == ST_STOP && coasting) ##1 start_pulse);
endmodule : ssim_top

// *** verification/ssim_sw_model.sv ***
// Purpose: Command switches wired to the five terminals
// Assumes: want is set by the bench after a clock edge
// Notes: Contacts chatter three cycles on every change
`timescale 1ns/1ps
module ssim_sw_model (
  input wire logic ref_clk,
  input wire logic [4:0] want,
  output logic [4:0] term_in
);
  logic [1:0] chat;
  logic [4:0] dif;
  initial begin
    term_in = 5'h00;
    chat = 2'h0;
    dif = 5'h00;
  end
  // Only the bits that moved chatter, so a quiet contact stays quiet
  always @(posedge ref_clk) begin
    if (chat != 2'h0) begin
      chat <= chat - 2'h1;
      term_in <= (chat == 2'h1) ? want : term_in ^ dif;
    end else if (term_in != want) begin
      dif <= term_in ^ want;
      chat <= 2'h3;
      term_in <= want;
    end
  end
endmodule : ssim_sw_model

// *** verification/stop_select_and_input_mapping_bench.sv ***
// Purpose: Self-checking bench for the stop select block
// Assumes: Filter and seconds counts shortened by parameters
// Notes: Register model in the bench decides expected read data and write responses
`timescale 1ns/1ps
module stop_select_and_input_mapping_bench import ssim_pkg::*;;
  localparam int FQ = 4;
  localparam int SL = 16;
  localparam int SC = 10;
  logic ref_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ramp_done;
  logic running, decel_req, reverse, coasting, start_pulse;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [4:0] term_in, sw;
  logic [NFUNC-1:0] func_out;
  int mdl [8];
  int legal [$] = '{0, 1, 2, 3, 4, 5, 7, 8, 10, 12, 14, 16, 18, 24, 25, 62,
    65, 66, 67, 9999};
  int bad [$] = '{6, 9, 60, 61, 100, 9998};
  int sbad [$] = '{101, 999, 1101, 8887};
  int miscompares, check_count, pulses, n0;
  ssim_top #(.FAST_CYC_P(FQ), .SLOW_CYC_P(SL), .SEC_CYC_P(SC)) dut_u (
    .ref_clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .term_in, .ramp_done, .running, .decel_req,
    .reverse, .coasting, .start_pulse, .func_out);
  ssim_sw_model sw_u (.ref_clk, .want(sw), .term_in);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (start_pulse === 1'b1) pulses <= pulses + 1;
  task automatic print_verdict();
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    // Several times the expected run length
    #200_000;
    miscompares++;
    print_verdict();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] ex,
                     input string m);
    check_count++;
    if (got !== ex) begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic st(input logic [2:0] e);
    chk(32'({running, decel_req, coasting}), 32'(e), "drive state");
  endtask : st
  function automatic bit ok_val(input int i, input int d);
    if (i == 0)
      return d <= 100 || d == 8888 || d == 9999 || (d >= 1000 && d <= 1100);
    if (i >= 1 && i <= 5) begin
      foreach (legal[k]) if (legal[k] == d) return 1'b1;
      return (d == 60 && i == 1) || (d == 61 && i == 2);
    end
    return i == 6;
  endfunction : ok_val
  task automatic wr(input int i, input int d);
    logic [1:0] er;
    bit done;
    int n;
    er = ok_val(i, d) ? 2'h0 : 2'h2;
    if (er == 2'h0) mdl[i] = (i == 6) ? (d & 'hf3) : d;
    awaddr <= 8'(i * 4);
    wdata <= 32'(d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Local flag: bready itself only updates after this time step
    done = 1'b0;
    n = 0;
    while (!done && n < 50) begin
      @(posedge ref_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        bready <= 1'b0;
        chk(32'(bresp), 32'(er), "write response");
      end
    end
    if (!done) chk(0, 1, "write hang");
    // Idle edge keeps the next request off this release step
    cyc(1);
  endtask : wr
  task automatic rd(input int i);
    bit done;
    int n;
    araddr <= 8'(i * 4);
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    n = 0;
    while (!done && n < 50) begin
      @(posedge ref_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        rready <= 1'b0;
        chk(rdata, (i < 8) ? 32'(mdl[i]) : 0, "read data");
        chk(32'(rresp), (i < 8) ? 0 : 2, "read response");
      end
    end
    if (!done) chk(0, 1, "read hang");
    cyc(1);
  endtask : rd
  initial begin
    void'($urandom(32'h86c242d3));
    {rst_n, awvalid, wvalid, bready, arvalid, rready, ramp_done} = 7'h00;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    wstrb = 4'hf;
    sw = 5'h00;
    mdl = '{9999, 60, 61, 0, 1, 2, 0, 0};
    cyc(4);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rd(i);
    foreach (legal[k]) begin
      wr(3, legal[k]);
      rd(3);
    end
    foreach (bad[k]) for (int i = 1; i < 6; i++) wr(i, bad[k]);
    for (int i = 1; i < 6; i++) rd(i);
    foreach (sbad[k]) wr(0, sbad[k]);
    wr(7, 0);
    wr(8, 1);
    rd(8);
    wr(3, 1);
    wr(0, 9999);
    sw <= 5'h01;
    cyc(SL + 12);
    st(3'b100);
    chk(reverse, 0, "forward direction");
    sw <= 5'h00;
    cyc(SL + 12);
    st(3'b110);
    ramp_done <= 1'b1;
    cyc(3);
    st(3'b000);
    ramp_done <= 1'b0;
    sw <= 5'h02;
    cyc(SL + 12);
    chk(reverse, 1, "reverse direction");
    sw <= 5'h03;
    cyc(SL + 12);
    st(3'b110);
    ramp_done <= 1'b1;
    cyc(3);
    ramp_done <= 1'b0;
    wr(0, 3);
    sw <= 5'h01;
    cyc(SL + 12);
    sw <= 5'h00;
    cyc(2 * SC + 4);
    sw <= 5'h01;
    cyc(SL + 12);
    sw <= 5'h00;
    cyc(SL + 2 * SC + 4);
    st(3'b100);
    cyc(SC + 12);
    st(3'b001);
    n0 = pulses;
    sw <= 5'h01;
    cyc(SL + 12);
    st(3'b100);
    chk(pulses - n0, 1, "restart pulse");
    wr(0, 1002);
    sw <= 5'h03;
    cyc(SL + 12);
    chk(reverse, 1, "direction input");
    sw <= 5'h02;
    cyc(SL + SC + 4);
    st(3'b100);
    cyc(SC + 12);
    st(3'b001);
    // Ramped stop with start plus direction inputs
    wr(0, 8888);
    sw <= 5'h03;
    cyc(SL + 12);
    st(3'b100);
    chk(reverse, 1, "start with direction");
    sw <= 5'h02;
    cyc(SL + 12);
    st(3'b110);
    ramp_done <= 1'b1;
    cyc(3);
    st(3'b000);
    ramp_done <= 1'b0;
    wr(0, 1002);
    wr(6, 'h10);
    sw <= 5'h01;
    cyc(SL + 12);
    sw <= 5'h00;
    cyc(SL + 12);
    st(3'b110);
    ramp_done <= 1'b1;
    cyc(3);
    ramp_done <= 1'b0;
    wr(5, 24);
    wr(6, 2);
    cyc(FQ + 14);
    chk(32'(func_out), 32'h0, "shutoff as permit low");
    sw <= 5'h10;
    cyc(FQ + 14);
    chk(32'(func_out), 32'h100, "shutoff as permit high");
    wr(4, 10);
    cyc(3);
    chk(32'(func_out), 32'h2000, "shutoff freed");
    sw <= 5'h18;
    cyc(FQ + 14);
    chk(32'(func_out), 32'h2100, "permit terminal");
    wr(6, 0);
    wr(4, 2);
    wr(5, 2);
    wr(3, 62);
    sw <= 5'h10;
    cyc(SL + 12);
    chk(32'(func_out), 32'h104, "shared code high");
    sw <= 5'h08;
    cyc(SL + 12);
    chk(32'(func_out), 32'h104, "shared code mid");
    sw <= 5'h04;
    cyc(SL + 12);
    chk(32'(func_out), 32'h20100, "reset code");
    wr(3, 9999);
    cyc(3);
    chk(32'(func_out), 32'h100, "no function");
    repeat (16) begin
      n0 = $urandom_range(5, 1);
      wr(n0, $urandom_range(70, 0));
      rd(n0);
    end
    print_verdict();
  end
endmodule : stop_select_and_input_mapping_bench
